//--- rtl/spicsl_top.sv
// Purpose: Control and status logic of the serial peripheral port
// Assumes: Shift engine, rate divider and configuration register sit outside
// Notes:   Register reached over the special function register port
//
// Overview of operation
// - Transfer completion sets transfer-done flag, bit 7
// - Any set flag with interrupts enabled requests interrupt
// - Flags stay set until software writes zero
// - Data write while buffer full: ignored, collision set
// - Select low, master, mode 01: mode fault
// - Slave last bit with unread receive data: overrun
// - Mode 00: three-wire, select pin unused
// - Mode 01, reset value: four-wire, select is input
// - Mode 1x: select pin driven with mode low bit
// - Buffer-empty bit reads zero after data written
// - Buffer moved to shifter sets buffer-empty bit
// - Master-enable one means master, zero means slave

`timescale 1ns/1ps

module spicsl_top
    import spicsl_pkg::*;
#(
    parameter int XFER_BITS = SPICSL_BITS_PER_XFER
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Special function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_bit_wr_in,
    input wire logic [7:0] sfr_bit_addr_in,
    input wire logic sfr_bit_val_in,
    output logic [7:0] sfr_rdata_out,
    // Configuration and interrupt system
    input wire logic master_enable_in,
    input wire logic int_enable_in,
    output logic irq_out,
    // Shift engine
    input wire logic master_xfer_done_in,
    input wire logic tx_load_in,
    input wire logic rx_unread_in,
    output logic port_enable_out,
    output logic tx_buf_wr_out,
    output logic [7:0] tx_buf_data_out,
    output logic slave_selected_out,
    // Serial pins
    input wire logic sck_pin_in,
    input wire logic slave_select_pin_in,
    output logic slave_select_pin_out,
    output logic slave_select_pin_oe_n_out
);

    initial begin
        if (XFER_BITS < 1 || XFER_BITS > 255) begin
            $error("spicsl_top: XFER_BITS must be 1..255");
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] pins_sync;
    logic sck_s;
    logic nss_s;

    spicsl_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({sck_pin_in, slave_select_pin_in}),
        .rst_val_in(2'h1),  // Link clock idles low, select idles high
        .sync_out(pins_sync)
    );

    assign sck_s = pins_sync[1];
    assign nss_s = pins_sync[0];

    // ****************************************************************
    // Software access decode
    // ****************************************************************
    spicsl_swr_t swr;
    logic data_wr;
    logic bit_hit;

    // Byte write or bit write into 0xF8..0xFF
    always_comb begin
        bit_hit = sfr_bit_wr_in && (sfr_bit_addr_in[7:3] == SPICSL_CTRL_BITBASE);
        swr.byte_wr = sfr_wr_in && (sfr_addr_in == SPICSL_CTRL_ADDR);
        swr.bit_wr = bit_hit;
        swr.bit_sel = sfr_bit_addr_in[2:0];
        swr.wdata = sfr_wdata_in;
        data_wr = sfr_wr_in && (sfr_addr_in == SPICSL_DATA_ADDR);
    end

    // Write strobe and value for one register bit
    function automatic logic [1:0] bit_write(input spicsl_swr_t w, input int pos);
        logic hit;
        logic val;
        hit = w.byte_wr || (w.bit_wr && (w.bit_sel == 3'(pos)));
        val = w.byte_wr ? w.wdata[pos] : sfr_bit_val_in;
        return {hit, val};
    endfunction : bit_write

    // ****************************************************************
    // Control fields: mode and port enable
    // ****************************************************************
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic en_r;
    logic en_nxt;
    logic [1:0] wm_hi;
    logic [1:0] wm_lo;
    logic [1:0] we_en;

    always_comb begin
        wm_hi = bit_write(swr, SPICSL_MODE_HI_BIT);
        wm_lo = bit_write(swr, SPICSL_MODE_LO_BIT);
        we_en = bit_write(swr, SPICSL_EN_BIT);
        mode_nxt = mode_r;
        en_nxt = en_r;
        if (wm_hi[1]) begin
            mode_nxt[1] = wm_hi[0];
        end
        if (wm_lo[1]) begin
            mode_nxt[0] = wm_lo[0];
        end
        if (we_en[1]) begin
            en_nxt = we_en[0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_r <= SPICSL_MODE_RST;
            en_r <= SPICSL_EN_RST;
        end else begin
            mode_r <= mode_nxt;
            en_r <= en_nxt;
        end
    end

    assign port_enable_out = en_r;

    // ****************************************************************
    // Slave select pin handling
    // ****************************************************************
    logic selected;
    logic is_master;

    assign is_master = master_enable_in;

    // Three-wire slaves count as always selected; the pin is ignored
    always_comb begin
        slave_select_pin_out = 1'b1;
        slave_select_pin_oe_n_out = 1'b1;
        selected = 1'b0;
        if (mode_r == SPICSL_MODE_3WIRE) begin
            selected = 1'b1;
        end else if (mode_r == SPICSL_MODE_4WIRE_IN) begin
            selected = !nss_s;
        end else begin
            slave_select_pin_out = mode_r[0];
            slave_select_pin_oe_n_out = 1'b0;
        end
    end

    assign slave_selected_out = en_r && !is_master && selected;

    // ****************************************************************
    // Slave bit counter on the sampled link clock
    // ****************************************************************
    spicsl_state_t state_r;
    spicsl_state_t state_nxt;
    logic [7:0] bitcnt_r;
    logic [7:0] bitcnt_nxt;
    logic sck_d_r;
    logic sck_rise;
    logic slave_last;

    // Rising edge of the synchronised link clock
    assign sck_rise = sck_s && !sck_d_r;

    // Counting restarts whenever the slave is deselected or disabled
    always_comb begin
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        slave_last = 1'b0;
        if (!slave_selected_out) begin
            state_nxt = SPICSL_S_IDLE;
            bitcnt_nxt = 8'h00;
        end else begin
            unique case (state_r)
                SPICSL_S_IDLE: begin
                    if (sck_rise) begin
                        bitcnt_nxt = 8'h01;
                        state_nxt = SPICSL_S_SHIFT;
                    end
                end
                SPICSL_S_SHIFT: begin
                    if (sck_rise) begin
                        bitcnt_nxt = bitcnt_r + 8'h01;
                    end
                end
                default: begin
                    state_nxt = SPICSL_S_IDLE;
                end
            endcase
            if (sck_rise && (bitcnt_nxt == 8'(XFER_BITS))) begin
                slave_last = 1'b1;
                bitcnt_nxt = 8'h00;
                state_nxt = SPICSL_S_IDLE;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= SPICSL_S_IDLE;
            bitcnt_r <= 8'h00;
            sck_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            sck_d_r <= sck_s;
        end
    end

    // ****************************************************************
    // Transmit buffer and its empty flag
    // ****************************************************************
    logic txe_r;
    logic txe_nxt;
    logic txw_r;
    logic txw_nxt;
    logic [7:0] txd_r;
    logic [7:0] txd_nxt;
    logic coll_evt;

    // Collision check guards against overwriting a byte not yet shifted
    always_comb begin
        txe_nxt = txe_r;
        txw_nxt = 1'b0;
        txd_nxt = txd_r;
        coll_evt = 1'b0;
        if (tx_load_in && en_r) begin
            txe_nxt = 1'b1;
        end
        if (data_wr) begin
            if (txe_r) begin
                txe_nxt = 1'b0;
                txw_nxt = 1'b1;
                txd_nxt = sfr_wdata_in;
            end else begin
                coll_evt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            txe_r <= SPICSL_TXE_RST;
            txw_r <= 1'b0;
            txd_r <= 8'h00;
        end else begin
            txe_r <= txe_nxt;
            txw_r <= txw_nxt;
            txd_r <= txd_nxt;
        end
    end

    assign tx_buf_wr_out = txw_r;
    assign tx_buf_data_out = txd_r;

    // ****************************************************************
    // Status flags
    // ****************************************************************
    spicsl_evt_t evt;
    logic [3:0] flags;
    logic [3:0] fl_wr;
    logic [3:0] fl_val;

    // Events gathered in register bit order
    always_comb begin
        evt.done = en_r && ((is_master && master_xfer_done_in) || (!is_master && slave_last));
        evt.collision = coll_evt;
        evt.fault = en_r && !nss_s && is_master && (mode_r == SPICSL_MODE_4WIRE_IN);
        evt.overrun = !is_master && slave_last && rx_unread_in;
    end

    genvar gf;
    generate
        for (gf = 0; gf < SPICSL_NFLAGS; gf++) begin : g_flag
            logic [1:0] wv;
            assign wv = bit_write(swr, SPICSL_OVRN_BIT + gf);
            assign fl_wr[gf] = wv[1];
            assign fl_val[gf] = wv[0];
            spicsl_flag u_flag (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .set_in(evt[gf]),
                .sw_wr_in(fl_wr[gf]),
                .sw_val_in(fl_val[gf]),
                .flag_out(flags[gf])
            );
        end
    endgenerate

    // Level request while any flag is pending
    assign irq_out = int_enable_in && (|flags);

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Unmapped reads return zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_rd_in && (sfr_addr_in == SPICSL_CTRL_ADDR)) begin
            rdata_nxt = {flags, mode_r, txe_r, en_r};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata_out = rdata_r;

endmodule : spicsl_top

//--- shared/spicsl_pkg.sv
// Purpose: Shared constants and types of the serial port control and status logic
// Assumes: 8-bit special function register space, 8051-style bit addressing
// Notes:   Every offset and field position of the block lives here, with the reset values of the register fields

package spicsl_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] SPICSL_CTRL_ADDR = 8'hF8;   // Control and status, bit-addressable
    localparam logic [7:0] SPICSL_DATA_ADDR = 8'hA3;   // Serial data register write port
    localparam logic [4:0] SPICSL_CTRL_BITBASE = 5'h1F; // Bit addresses 0xF8..0xFF

    // ****************************************************************
    // Field positions of the control and status register
    // ****************************************************************
    localparam int SPICSL_DONE_BIT = 7;
    localparam int SPICSL_COLL_BIT = 6;
    localparam int SPICSL_FAULT_BIT = 5;
    localparam int SPICSL_OVRN_BIT = 4;
    localparam int SPICSL_MODE_HI_BIT = 3;
    localparam int SPICSL_MODE_LO_BIT = 2;
    localparam int SPICSL_TXE_BIT = 1;
    localparam int SPICSL_EN_BIT = 0;
    localparam int SPICSL_NFLAGS = 4;

    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [3:0] SPICSL_FLAGS_RST = 4'h0;
    localparam logic [1:0] SPICSL_MODE_RST = 2'h1;
    localparam logic SPICSL_TXE_RST = 1'b1;
    localparam logic SPICSL_EN_RST = 1'b0;
    localparam logic [1:0] SPICSL_MODE_3WIRE = 2'h0;
    localparam logic [1:0] SPICSL_MODE_4WIRE_IN = 2'h1;
    localparam int SPICSL_BITS_PER_XFER = 8;
    localparam int SPICSL_SYNC_STAGES = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Status events, packed in register order (done in bit 3)
    typedef struct packed {
        logic done;
        logic collision;
        logic fault;
        logic overrun;
    } spicsl_evt_t;

    // Software access to the control register
    typedef struct packed {
        logic byte_wr;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } spicsl_swr_t;

    typedef enum logic [1:0] {
        SPICSL_S_IDLE = 2'b01,
        SPICSL_S_SHIFT = 2'b10
    } spicsl_state_t;

endpackage : spicsl_pkg

//--- rtl/spicsl_sync.sv
// Purpose: Two-stage synchroniser for pin inputs, one chain per bit
// Assumes: Inputs are asynchronous to clk_in
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

module spicsl_sync
    import spicsl_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] rst_val_in,
    output logic [WIDTH-1:0] sync_out
);

    initial begin
        if (WIDTH < 1) begin
            $error("spicsl_sync: WIDTH must be at least 1");
        end
    end

    // ****************************************************************
    // Synchroniser chains
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            logic stab_r;
            // Reset to the pin's idle level, so no false edge follows reset
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta_r <= rst_val_in[gi];
                    stab_r <= rst_val_in[gi];
                end else begin
                    meta_r <= async_in[gi];
                    stab_r <= meta_r;
                end
            end
            assign sync_out[gi] = stab_r;
        end
    endgenerate

endmodule : spicsl_sync

//--- rtl/spicsl_flag.sv
// Purpose: One sticky status flag set by hardware, written by software
// Assumes: Set and software write are single-cycle strobes
// Notes:   A hardware set in the same cycle as a software clear wins

`timescale 1ns/1ps

module spicsl_flag
    import spicsl_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Controls
    input wire logic set_in,
    input wire logic sw_wr_in,
    input wire logic sw_val_in,
    output logic flag_out
);

    logic flag_r;
    logic flag_nxt;

    // Hardware never clears; only software writes a zero
    always_comb begin
        flag_nxt = flag_r;
        if (sw_wr_in) begin
            flag_nxt = sw_val_in;
        end
        if (set_in) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_out = flag_r;

endmodule : spicsl_flag

//--- tb/spicsl_far_master.sv
// Purpose: Behavioural far-side serial master driving clock and select
// Assumes: Select line has a pull-up; clock idles low between frames
// Notes:   Link clock period 160 ns, unrelated to the system clock

`timescale 1ns/1ps

module spicsl_far_master (
    // Serial side
    output logic sck_out,
    output logic sel_out,
    output logic sel_en_out
);
    // Idle: clock still, select released to the pull-up
    initial begin
        sck_out = 1'b0;
        sel_out = 1'b1;
        sel_en_out = 1'b0;
    end

    // Drive the select line; low selects the device
    task automatic select(input logic v);
        sel_en_out = 1'b1;
        sel_out = v;
    endtask : select

    // Release: the inverse of the last value, so only the pull-up shows
    task automatic release_sel();
        sel_en_out = 1'b0;
        sel_out = ~sel_out;
    endtask : release_sel

    // One framed transfer of a given number of clock pulses
    task automatic frame(input int bits);
        select(1'b0);
        #83;
        repeat (bits) begin
            sck_out = 1'b1;
            #80;
            sck_out = 1'b0;
            #80;
        end
        release_sel();
    endtask : frame
endmodule : spicsl_far_master

//--- tb/spicsl_top_monitor.sv
// Purpose: Port-level checks of the serial control and status logic
// Assumes: One clock domain, synchronous reset
// Notes:   Shadows the select mode field from software writes

`timescale 1ns/1ps

module spicsl_monitor
    import spicsl_pkg::*;
#(
    parameter int XFER_BITS = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_bit_wr_in,
    input wire logic [7:0] sfr_bit_addr_in,
    input wire logic sfr_bit_val_in,
    input wire logic [7:0] sfr_rdata_out,
    // Configuration, interrupt and shift engine
    input wire logic master_enable_in,
    input wire logic int_enable_in,
    input wire logic irq_out,
    input wire logic master_xfer_done_in,
    input wire logic tx_load_in,
    input wire logic rx_unread_in,
    input wire logic port_enable_out,
    input wire logic tx_buf_wr_out,
    input wire logic [7:0] tx_buf_data_out,
    input wire logic slave_selected_out,
    // Serial pins
    input wire logic sck_pin_in,
    input wire logic slave_select_pin_in,
    input wire logic slave_select_pin_out,
    input wire logic slave_select_pin_oe_n_out
);
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic data_wr;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Mode shadow: byte writes and bit writes to bits 2 and 3
    assign data_wr = sfr_wr_in && sfr_addr_in == SPICSL_DATA_ADDR;
    always_comb begin
        mode_nxt = mode_r;
        if (sfr_wr_in && sfr_addr_in == SPICSL_CTRL_ADDR) mode_nxt = sfr_wdata_in[3:2];
        if (sfr_bit_wr_in && sfr_bit_addr_in == 8'hFA) mode_nxt[0] = sfr_bit_val_in;
        if (sfr_bit_wr_in && sfr_bit_addr_in == 8'hFB) mode_nxt[1] = sfr_bit_val_in;
    end
    always_ff @(posedge clk_in) begin
        mode_r <= rst_in ? SPICSL_MODE_RST : mode_nxt;
    end

    AST_DONE_IRQ: assert property (
        port_enable_out && master_enable_in && master_xfer_done_in && int_enable_in ##1 int_enable_in |-> irq_out)
        else $error("transfer done did not raise the request");
    AST_IRQ_OFF: assert property (!int_enable_in |-> !irq_out)
        else $error("request raised while interrupts disabled");
    AST_STICKY: assert property (
        $past(irq_out) && int_enable_in && !$past(sfr_wr_in || sfr_bit_wr_in) |-> irq_out)
        else $error("flag cleared without a software write");
    AST_COLL_IRQ: assert property (
        tx_buf_wr_out && data_wr && int_enable_in ##1 int_enable_in |-> irq_out && !tx_buf_wr_out)
        else $error("write to full buffer not refused with collision");
    AST_TX_CAUSE: assert property (tx_buf_wr_out |-> $past(data_wr) && tx_buf_data_out == $past(sfr_wdata_in))
        else $error("buffer write without matching data write");
    AST_SEL_OE: assert property (slave_select_pin_oe_n_out == !mode_r[1])
        else $error("select pin drive does not follow mode");
    AST_SEL_VAL: assert property (!slave_select_pin_oe_n_out |-> slave_select_pin_out == mode_r[0])
        else $error("driven select level differs from mode low bit");
    AST_RD_IDLE: assert property (!$past(sfr_rd_in) |-> sfr_rdata_out == 8'h00)
        else $error("read data not zero without read");
    AST_EN_RST: assert property ($past(rst_in) |-> !port_enable_out)
        else $error("port enabled right after reset");
    AST_SLV_ONLY: assert property (slave_selected_out |-> port_enable_out && !master_enable_in)
        else $error("selected as slave while master or disabled");

    // Main scenarios reached
    CVR_COLL: cover property (tx_buf_wr_out && data_wr);
    CVR_SLV: cover property (slave_selected_out && sck_pin_in);
    CVR_IRQ: cover property ($rose(irq_out));
endmodule : spicsl_monitor

bind spicsl_top spicsl_monitor #(.XFER_BITS(XFER_BITS)) i_mon (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_bit_wr_in(sfr_bit_wr_in),
    .sfr_bit_addr_in(sfr_bit_addr_in), .sfr_bit_val_in(sfr_bit_val_in), .sfr_rdata_out(sfr_rdata_out),
    .master_enable_in(master_enable_in), .int_enable_in(int_enable_in), .irq_out(irq_out),
    .master_xfer_done_in(master_xfer_done_in), .tx_load_in(tx_load_in), .rx_unread_in(rx_unread_in),
    .port_enable_out(port_enable_out), .tx_buf_wr_out(tx_buf_wr_out), .tx_buf_data_out(tx_buf_data_out),
    .slave_selected_out(slave_selected_out), .sck_pin_in(sck_pin_in),
    .slave_select_pin_in(slave_select_pin_in), .slave_select_pin_out(slave_select_pin_out),
    .slave_select_pin_oe_n_out(slave_select_pin_oe_n_out));

//--- tb/tb_spicsl_top.sv
// Purpose: Self-checking bench of the serial control and status logic
// Assumes: Register port timing as handed over; far master model on the pins
// Notes:   Expected register images given as literal hex values

`timescale 1ns/1ps

module tb_spicsl_top
    import spicsl_pkg::*;
;
    logic clk_in, rst_in, sfr_wr_in, sfr_rd_in, sfr_bit_wr_in, sfr_bit_val_in, irq_out;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_bit_addr_in, sfr_rdata_out, tx_buf_data_out;
    logic master_enable_in, int_enable_in, master_xfer_done_in, tx_load_in, rx_unread_in;
    logic port_enable_out, tx_buf_wr_out, slave_selected_out, ss_out, ss_oe_n, sck, far_ss, far_en;
    logic ss_pin;
    int bad_count = 0;
    int checks_done = 0;

    // Pull-up holds the select line high when nobody drives it
    assign ss_pin = !ss_oe_n ? ss_out : (far_en ? far_ss : 1'b1);

    spicsl_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_bit_wr_in(sfr_bit_wr_in),
        .sfr_bit_addr_in(sfr_bit_addr_in), .sfr_bit_val_in(sfr_bit_val_in), .sfr_rdata_out(sfr_rdata_out),
        .master_enable_in(master_enable_in), .int_enable_in(int_enable_in), .irq_out(irq_out),
        .master_xfer_done_in(master_xfer_done_in), .tx_load_in(tx_load_in), .rx_unread_in(rx_unread_in),
        .port_enable_out(port_enable_out), .tx_buf_wr_out(tx_buf_wr_out), .tx_buf_data_out(tx_buf_data_out),
        .slave_selected_out(slave_selected_out), .sck_pin_in(sck), .slave_select_pin_in(ss_pin),
        .slave_select_pin_out(ss_out), .slave_select_pin_oe_n_out(ss_oe_n));
    spicsl_far_master i_far (.sck_out(sck), .sel_out(far_ss), .sel_en_out(far_en));

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Byte write; returns just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
        #1;
    endtask : wr

    task automatic bwr(input logic [7:0] a, input logic v);
        @(posedge clk_in);
        sfr_bit_wr_in <= 1'b1;
        sfr_bit_addr_in <= a;
        sfr_bit_val_in <= v;
        @(posedge clk_in);
        sfr_bit_wr_in <= 1'b0;
        #1;
    endtask : bwr

    // Read data is registered at the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        sfr_rd_in <= 1'b1;
        sfr_addr_in <= a;
        @(posedge clk_in);
        sfr_rd_in <= 1'b0;
        #1;
        check("register read", sfr_rdata_out, exp);
    endtask : rd

    // One-cycle strobe from the shift engine
    task automatic pulse(input bit load);
        @(posedge clk_in);
        if (load) tx_load_in <= 1'b1;
        else master_xfer_done_in <= 1'b1;
        @(posedge clk_in);
        tx_load_in <= 1'b0;
        master_xfer_done_in <= 1'b0;
        #1;
    endtask : pulse

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst_in, int_enable_in} = 2'b11;
        {sfr_wr_in, sfr_rd_in, sfr_bit_wr_in, sfr_bit_val_in, master_enable_in} = '0;
        {master_xfer_done_in, tx_load_in, rx_unread_in} = '0;
        {sfr_addr_in, sfr_wdata_in, sfr_bit_addr_in} = '0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(SPICSL_CTRL_ADDR, 8'h06);
        check("select oe_n", 8'(ss_oe_n), 8'h01);
        rd(8'h10, 8'h00);
        wr(SPICSL_CTRL_ADDR, 8'h05);
        check("enable", 8'(port_enable_out), 8'h01);
        // Back-to-back data writes: second one meets a full buffer
        @(posedge clk_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= SPICSL_DATA_ADDR;
        sfr_wdata_in <= 8'h5A;
        @(posedge clk_in);
        sfr_wdata_in <= 8'h33;
        #1;
        check("tx write", 8'(tx_buf_wr_out), 8'h01);
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
        #1;
        check("tx data", tx_buf_data_out, 8'h5A);
        check("tx write", 8'(tx_buf_wr_out), 8'h00);
        check("irq", 8'(irq_out), 8'h01);
        repeat (20) @(posedge clk_in);
        rd(SPICSL_CTRL_ADDR, 8'h45);
        pulse(1'b1);
        rd(SPICSL_CTRL_ADDR, 8'h47);
        wr(SPICSL_CTRL_ADDR, 8'h05);
        check("irq", 8'(irq_out), 8'h00);
        master_enable_in <= 1'b1;
        pulse(1'b0);
        rd(SPICSL_CTRL_ADDR, 8'h87);
        check("slave selected", 8'(slave_selected_out), 8'h00);
        bwr(8'hFF, 1'b0);
        rd(SPICSL_CTRL_ADDR, 8'h07);
        i_far.select(1'b0);
        repeat (6) @(posedge clk_in);
        rd(SPICSL_CTRL_ADDR, 8'h27);
        i_far.release_sel();
        repeat (3) @(posedge clk_in); // Synchronised select must be high before the clear
        wr(SPICSL_CTRL_ADDR, 8'h05);
        master_enable_in <= 1'b0;
        rx_unread_in <= 1'b1;
        i_far.frame(SPICSL_BITS_PER_XFER);
        repeat (4) @(posedge clk_in);
        rd(SPICSL_CTRL_ADDR, 8'h97);
        wr(SPICSL_CTRL_ADDR, 8'h04);
        master_enable_in <= 1'b1;
        pulse(1'b0);
        rd(SPICSL_CTRL_ADDR, 8'h06);
        master_enable_in <= 1'b0;
        wr(SPICSL_CTRL_ADDR, 8'h01);
        check("three-wire select", {6'h00, ss_oe_n, slave_selected_out}, 8'h03);
        wr(SPICSL_CTRL_ADDR, 8'h09);
        check("select drive", {6'h00, ss_oe_n, ss_pin}, 8'h00);
        wr(SPICSL_CTRL_ADDR, 8'h0D);
        check("select drive", {6'h00, ss_oe_n, ss_pin}, 8'h01);
        summarize();
    end
endmodule : tb_spicsl_top
